/* File: verilog/ufc_top.sv */
// Unsigned float conversion datapath with predication and sticky flags
`timescale 1ns/1ps
`default_nettype none
module ufc_top (
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        op_valid_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [2:0]  slot_i,
    input  wire logic        guard_present_i,
    input  wire logic [31:0] guard_i,
    input  wire logic [31:0] first_operand_reg_i,
    input  wire logic [6:0]  dest_i,
    input  wire logic [1:0]  rnd_mode_i,
    input  wire logic        sw_flag_wr_i,
    input  wire logic [6:0]  sw_flag_wdata_i,
    input  wire logic [6:0]  ext_flag_set_i,
    output logic             wr_en_o,
    output logic [6:0]       wr_dest_o,
    output logic [31:0]      wr_data_o,
    output logic [6:0]       sw_flags_o,
    output logic             illegal_o
);
    // ------------------------------------------------------------
    // Issue decode
    // ------------------------------------------------------------
    logic is_known;
    logic slot_ok;
    logic guard_ok;
    logic accept;
    logic is_f2u;
    logic is_query;
    logic is_rz;

    // Opcode classes and issue qualification
    always_comb begin
        is_f2u   = (opcode_i == ufc_pkg::OPC_F2U_RZ) || (opcode_i == ufc_pkg::OPC_F2U_RZ_Q);
        is_query = (opcode_i == ufc_pkg::OPC_F2U_RZ_Q) || (opcode_i == ufc_pkg::OPC_U2F_Q)
                 || (opcode_i == ufc_pkg::OPC_U2F_RZ_Q);
        is_rz    = (opcode_i == ufc_pkg::OPC_U2F_RZ) || (opcode_i == ufc_pkg::OPC_U2F_RZ_Q);
        is_known = is_f2u || is_query || is_rz || (opcode_i == ufc_pkg::OPC_U2F);
        slot_ok  = (slot_i == ufc_pkg::SLOT_A) || (slot_i == ufc_pkg::SLOT_B);
        guard_ok = !guard_present_i || guard_i[0];
        accept   = op_valid_i && is_known && slot_ok && guard_ok;
    end

    // ------------------------------------------------------------
    // Stage 1: capture operand, flush denormals
    // ------------------------------------------------------------
    logic        s1_valid;
    logic        s1_f2u;
    logic        s1_query;
    logic [1:0]  s1_mode;
    logic [31:0] s1_src;
    logic        s1_ifz;
    logic [6:0]  s1_dest;
    logic        denorm;

    assign denorm = (first_operand_reg_i[30:23] == 8'h00) && (first_operand_reg_i[22:0] != 23'h0);

    // Valid bit of stage 1
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_valid <= 1'b0;
        end else begin
            s1_valid <= accept;
        end
    end

    // Operand and mode capture
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_f2u   <= 1'b0;
            s1_query <= 1'b0;
            s1_mode  <= ufc_pkg::RM_ZERO;
            s1_src   <= ufc_pkg::WORD_ZERO;
            s1_ifz   <= 1'b0;
            s1_dest  <= 7'h00;
        end else if (accept) begin
            s1_f2u   <= is_f2u;
            s1_query <= is_query;
            s1_mode  <= (is_f2u || is_rz) ? ufc_pkg::RM_ZERO : rnd_mode_i;
            s1_src   <= (is_f2u && denorm) ? ufc_pkg::WORD_ZERO : first_operand_reg_i;
            s1_ifz   <= is_f2u && denorm;
            s1_dest  <= dest_i;
        end
    end

    // Refused issue from a slot other than one or four
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= op_valid_i && is_known && !slot_ok;
        end
    end

    // ------------------------------------------------------------
    // Stage 2: conversion arithmetic
    // ------------------------------------------------------------
    logic [31:0] u2f_res;
    logic        u2f_inx;
    logic [31:0] f2u_res;
    logic [6:0]  f2u_flg;
    logic [54:0] f2u_wide;
    logic [7:0]  f_exp;

    ufc_u2f_round u_u2f (
        .src_i      (s1_src),
        .rnd_mode_i (s1_mode),
        .result_o   (u2f_res),
        .inexact_o  (u2f_inx)
    );

    // Truncating float to unsigned; always toward zero
    always_comb begin
        f_exp    = s1_src[30:23];
        f2u_res  = ufc_pkg::WORD_ZERO;
        f2u_flg  = ufc_pkg::FLAGS_RST;
        f2u_wide = {31'h00000000, 1'b1, s1_src[22:0]} << (f_exp - ufc_pkg::EXP_BIAS);
        f2u_flg[ufc_pkg::FB_IFZ] = s1_ifz;
        if (f_exp == ufc_pkg::EXP_TOP) begin
            f2u_flg[ufc_pkg::FB_INV] = 1'b1;
            if (s1_src[22:0] == 23'h0 && !s1_src[31]) begin
                f2u_res = ufc_pkg::WORD_ONES;
            end
        end else if (f_exp == 8'h00) begin
            f2u_res = ufc_pkg::WORD_ZERO;
        end else if (s1_src[31]) begin
            f2u_flg[ufc_pkg::FB_INV] = 1'b1;
        end else if (f_exp < ufc_pkg::EXP_BIAS) begin
            f2u_flg[ufc_pkg::FB_INX] = 1'b1;
        end else if (f_exp > ufc_pkg::EXP_INT_MAX) begin
            f2u_flg[ufc_pkg::FB_INV] = 1'b1;
            f2u_res = ufc_pkg::WORD_ONES;
        end else begin
            f2u_res = f2u_wide[54:23];
            f2u_flg[ufc_pkg::FB_INX] = |f2u_wide[22:0];
        end
    end

    logic        s2_valid;
    logic        s2_query;
    logic [31:0] s2_res;
    logic [6:0]  s2_flg;
    logic [6:0]  s2_dest;

    // Stage 2 registers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s2_valid <= 1'b0;
            s2_query <= 1'b0;
            s2_res   <= ufc_pkg::WORD_ZERO;
            s2_flg   <= ufc_pkg::FLAGS_RST;
            s2_dest  <= 7'h00;
        end else begin
            s2_valid <= s1_valid;
            s2_query <= s1_query;
            s2_res   <= s1_f2u ? f2u_res : u2f_res;
            s2_flg   <= s1_f2u ? f2u_flg : {5'h00, u2f_inx, 1'b0};
            s2_dest  <= s1_dest;
        end
    end

    // ------------------------------------------------------------
    // Stage 3: target write and sticky flags
    // ------------------------------------------------------------
    logic [6:0] flag_upd;

    assign flag_upd = (s2_valid && !s2_query) ? s2_flg : ufc_pkg::FLAGS_RST;

    // Target write three cycles after issue
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_en_o   <= 1'b0;
            wr_dest_o <= 7'h00;
            wr_data_o <= ufc_pkg::WORD_ZERO;
        end else begin
            wr_en_o   <= s2_valid;
            wr_dest_o <= s2_dest;
            wr_data_o <= s2_query ? {25'h0000000, s2_flg} : s2_res;
        end
    end

    // Sticky flags; a set in the clearing cycle wins over the clear
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sw_flags_o <= ufc_pkg::FLAGS_RST;
        end else begin
            sw_flags_o <= (sw_flag_wr_i ? sw_flag_wdata_i : sw_flags_o)
                        | flag_upd | ext_flag_set_i;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence issue_ok;
        accept;
    endsequence

    sequence lands;
        ##3 wr_en_o;
    endsequence

    a_result_latency: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        issue_ok |-> lands) else $error("result not written three cycles after issue");

    a_guard_false_block: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        op_valid_i && !guard_ok |-> ##2 (flag_upd == ufc_pkg::FLAGS_RST) ##1 !wr_en_o)
        else $error("false guard still wrote");

    a_slot_refused: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        op_valid_i && is_known && !slot_ok |-> ##1 illegal_o ##2 !wr_en_o)
        else $error("bad slot not refused");

    a_query_no_flags: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        s2_valid && s2_query && !sw_flag_wr_i && ext_flag_set_i == ufc_pkg::FLAGS_RST
        |=> $stable(sw_flags_o)) else $error("query changed sticky flags");

    a_flags_sticky: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        !sw_flag_wr_i |=> (sw_flags_o & $past(sw_flags_o)) == $past(sw_flags_o))
        else $error("sticky flag lost without write");

    a_query_upper_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        issue_ok and (is_query) |-> ##3 wr_data_o[31:7] == 25'h0000000)
        else $error("flag vector upper bits not zero");

    a_denorm_flush: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        issue_ok and (opcode_i == ufc_pkg::OPC_F2U_RZ_Q && denorm)
        |-> ##3 wr_data_o == 32'h0000_0020) else $error("denormal not flagged");

    a_pos_inf_ones: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        issue_ok and (opcode_i == ufc_pkg::OPC_F2U_RZ && first_operand_reg_i == 32'h7F80_0000)
        |-> ##3 wr_data_o == ufc_pkg::WORD_ONES && sw_flags_o[ufc_pkg::FB_INV])
        else $error("positive infinity result wrong");

    a_value_sets_flag: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        s2_valid && !s2_query |=> (sw_flags_o & $past(s2_flg)) == $past(s2_flg))
        else $error("raised flag not merged");
endmodule
`default_nettype wire

/* File: verilog/ufc_pkg.sv */
// Constants shared by the unsigned float conversion unit
//
// Function
// - Opcode 126 writes the exception vector that truncating float-to-unsigned would raise.
// - The flag-query operations write only their target and never touch the sticky flags.
// - Float-to-unsigned truncation and its query always round toward zero, ignoring mode bits.
// - A denormal float source is replaced by zero and the query sets the input-flushed bit.
// - The flag vector has divide-by-zero at bit 0 up to output-flushed at bit 6, rest zero.
// - Opcode 127 converts unsigned to float rounding by the status-word mode bits.
// - A converting operation that raises an exception sets the matching status-word flags.
// - Status-word flags are sticky and are cleared only by an explicit status-word write.
// - Flags update in the target write cycle, ORed with other units' updates and old value.
// - A false guard on a value-producing conversion blocks both target and flag writes.
// - The guard's least significant bit gates the target write; no guard means true.
// - Opcode 128 writes the exception vector of the mode-rounded unsigned-to-float.
// - Opcode 119 converts unsigned to float toward zero and updates the sticky flags.
// - Opcode 120 writes the exception vector of the truncating unsigned-to-float only.
// - Opcode 125 writes the truncated unsigned result and sets the matching flags.
package ufc_pkg;
    localparam int          OPC_W      = 8;
    localparam logic [7:0]  OPC_F2U_RZ = 8'h7D;
    localparam logic [7:0]  OPC_F2U_RZ_Q = 8'h7E;
    localparam logic [7:0]  OPC_U2F    = 8'h7F;
    localparam logic [7:0]  OPC_U2F_Q  = 8'h80;
    localparam logic [7:0]  OPC_U2F_RZ = 8'h77;
    localparam logic [7:0]  OPC_U2F_RZ_Q = 8'h78;
    localparam logic [2:0]  SLOT_A     = 3'h1;
    localparam logic [2:0]  SLOT_B     = 3'h4;
    localparam int          FLAG_W     = 7;
    localparam int          FB_DBZ     = 0;
    localparam int          FB_INX     = 1;
    localparam int          FB_UNF     = 2;
    localparam int          FB_OVF     = 3;
    localparam int          FB_INV     = 4;
    localparam int          FB_IFZ     = 5;
    localparam int          FB_OFZ     = 6;
    localparam logic [6:0]  FLAGS_RST  = 7'h00;
    localparam logic [1:0]  RM_NEAREST = 2'h0;
    localparam logic [1:0]  RM_ZERO    = 2'h1;
    localparam logic [1:0]  RM_POS     = 2'h2;
    localparam logic [1:0]  RM_NEG     = 2'h3;
    localparam logic [7:0]  EXP_BIAS   = 8'h7F;
    localparam logic [7:0]  EXP_TOP    = 8'hFF;
    localparam logic [7:0]  EXP_INT_MAX = 8'h9E;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [31:0] WORD_ONES  = 32'hFFFF_FFFF;
endpackage

/* File: verilog/ufc_u2f_round.sv */
// Unsigned integer to single-precision float with selectable rounding
`timescale 1ns/1ps
`default_nettype none
module ufc_u2f_round (
    input  wire logic [31:0] src_i,
    input  wire logic [1:0]  rnd_mode_i,
    output logic      [31:0] result_o,
    output logic             inexact_o
);
    logic [4:0]  lead;
    logic [31:0] norm;
    logic        grd;
    logic        stk;
    logic        up;
    logic [23:0] mant;
    logic [7:0]  expo;

    // Leading one position and normalisation
    always_comb begin
        lead = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (src_i[i]) begin
                lead = 5'(i);
            end
        end
        norm = src_i << (5'h1F - lead);
        grd  = norm[7];
        stk  = |norm[6:0];
    end

    // Rounding decision; the source is never negative
    always_comb begin
        unique case (rnd_mode_i)
            ufc_pkg::RM_NEAREST: up = grd & (stk | norm[8]);
            ufc_pkg::RM_ZERO:    up = 1'b0;
            ufc_pkg::RM_POS:     up = grd | stk;
            ufc_pkg::RM_NEG:     up = 1'b0;
        endcase
    end

    // Mantissa increment; a carry moves into the exponent
    always_comb begin
        mant = {1'b0, norm[30:8]} + {23'h000000, up};
        expo = ufc_pkg::EXP_BIAS + {3'h0, lead} + {7'h00, mant[23]};
        if (src_i == ufc_pkg::WORD_ZERO) begin
            result_o = ufc_pkg::WORD_ZERO;
        end else begin
            result_o = {1'b0, expo, mant[23] ? 23'h000000 : mant[22:0]};
        end
        inexact_o = grd | stk;
    end
endmodule
`default_nettype wire

/* File: bench/ufc_regfile_model.sv */
// Register-file model on the far side of the conversion unit
`timescale 1ns/1ps
`default_nettype none
module ufc_regfile_model (
    input  wire logic        core_clk_i,
    input  wire logic        wr_en_i,
    input  wire logic [6:0]  wr_dest_i,
    input  wire logic [31:0] wr_data_i,
    output logic      [31:0] wr_cnt_o,
    output logic      [6:0]  last_dest_o
);
    logic [31:0] regs [0:127];
    initial wr_cnt_o = 32'h0000_0000;
    // Store each accepted write and count it, so stray writes show up
    always @(posedge core_clk_i) begin
        if (wr_en_i === 1'b1) begin
            regs[wr_dest_i] <= wr_data_i;
            last_dest_o     <= wr_dest_i;
            wr_cnt_o        <= wr_cnt_o + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking testbench for the unsigned float conversion unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, gp = 1'b0, swr = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [2:0] slot = 3'h0;
    logic [1:0] rnd = 2'h0;
    logic [31:0] guard = 32'h0, src = 32'h0, wr_data, wr_cnt, got_data, got_flags, n0;
    logic [6:0] dest = 7'h00, swd = 7'h00, ext = 7'h00, wr_dest, sw_flags, last_dest;
    logic wr_en, illegal, got_en, got_ill;
    int error_cnt = 0, cmp_count = 0;
    logic [70:0] f_tab [8] = '{{32'h4040_0000, 32'h3, 7'h00}, {32'h4024_7AE1, 32'h2, 7'h02},
        {32'hFF7F_FFFF, 32'h0, 7'h10}, {32'h7F80_0000, 32'hFFFF_FFFF, 7'h10},
        {32'hBFC1_47AE, 32'h0, 7'h10}, {32'h0040_0000, 32'h0, 7'h20},
        {32'hFFFF_FFFF, 32'h0, 7'h10}, {32'hFFBF_FFFF, 32'h0, 7'h10}};
    logic [80:0] u_tab [15] = '{{8'h7F, 2'h0, 32'h3, 32'h4040_0000, 7'h00},
        {8'h7F, 2'h0, 32'hFFFF_FFFF, 32'h4F80_0000, 7'h02},
        {8'h7F, 2'h0, 32'h7FFF_FFFF, 32'h4F00_0000, 7'h02},
        {8'h7F, 2'h0, 32'h8000_0000, 32'h4F00_0000, 7'h00},
        {8'h7F, 2'h0, 32'h7FFF_FFF1, 32'h4F00_0000, 7'h02},
        {8'h7F, 2'h1, 32'hFFFF_FFFF, 32'h4F7F_FFFF, 7'h02},
        {8'h7F, 2'h2, 32'h7FFF_FFF1, 32'h4F00_0000, 7'h02},
        {8'h7F, 2'h3, 32'hFFFF_FFFF, 32'h4F7F_FFFF, 7'h02},
        {8'h77, 2'h2, 32'hFFFF_FFFF, 32'h4F7F_FFFF, 7'h02},
        {8'h77, 2'h0, 32'h7FFF_FFFF, 32'h4EFF_FFFF, 7'h02},
        {8'h77, 2'h0, 32'h7FFF_FFF1, 32'h4EFF_FFFF, 7'h02},
        {8'h80, 2'h0, 32'hFFFF_FFFF, 32'h2, 7'h02}, {8'h80, 2'h0, 32'h8000_0000, 32'h0, 7'h00},
        {8'h78, 2'h2, 32'h7FFF_FFF1, 32'h2, 7'h02}, {8'h78, 2'h0, 32'h3, 32'h0, 7'h00}};

    ufc_top DUT (.core_clk_i(core_clk), .arst_n_i(arst_n), .op_valid_i(op_valid),
        .opcode_i(opcode), .slot_i(slot), .guard_present_i(gp), .guard_i(guard),
        .first_operand_reg_i(src), .dest_i(dest), .rnd_mode_i(rnd), .sw_flag_wr_i(swr),
        .sw_flag_wdata_i(swd), .ext_flag_set_i(ext), .wr_en_o(wr_en), .wr_dest_o(wr_dest),
        .wr_data_o(wr_data), .sw_flags_o(sw_flags), .illegal_o(illegal));
    ufc_regfile_model rf (.core_clk_i(core_clk), .wr_en_i(wr_en), .wr_dest_i(wr_dest),
        .wr_data_i(wr_data), .wr_cnt_o(wr_cnt), .last_dest_o(last_dest));

    // ------------------------------------------------------------
    // Clock, shared tasks
    // ------------------------------------------------------------
    always #4 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Issue one op at a falling edge, sample just after the landing edge three cycles later
    task automatic run_op(input logic [7:0] opc, input logic [2:0] sl, input logic [1:0] rm,
                          input logic [31:0] s, input logic [31:0] g, input logic [6:0] e);
        @(negedge core_clk);
        {op_valid, opcode, slot, rnd, src, guard, dest} = {1'b1, opc, sl, rm, s, g, s[6:0]};
        @(negedge core_clk);
        got_ill = illegal;
        op_valid = 1'b0;
        @(negedge core_clk);
        ext = e;
        @(negedge core_clk);
        {got_en, got_data, got_flags} = {wr_en, wr_data, 25'h0, sw_flags};
        if (wr_en === 1'b1) check({25'h0, wr_dest}, {25'h0, s[6:0]});
        ext = 7'h00;
    endtask

    task automatic clear_flags();
        @(negedge core_clk);
        swr = 1'b1;
        @(negedge core_clk);
        swr = 1'b0;
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_f2u();
        foreach (f_tab[i]) begin
            run_op(8'h7E, 3'h1, 2'h2, f_tab[i][70:39], 32'h1, 7'h00);
            check(got_data, {25'h0, f_tab[i][6:0]});
            check(got_flags, 32'h0);
            run_op(8'h7D, 3'h4, 2'h3, f_tab[i][70:39], 32'h1, 7'h00);
            check(got_data, f_tab[i][38:7]);
            check(got_flags, {25'h0, f_tab[i][6:0]});
            clear_flags();
        end
        $display("float to unsigned test done");
    endtask

    task automatic t_u2f();
        foreach (u_tab[i]) begin
            run_op(u_tab[i][80:73], 3'h1, u_tab[i][72:71], u_tab[i][70:39], 32'h1, 7'h00);
            check(got_data, u_tab[i][38:7]);
            check(got_flags, u_tab[i][73] ? {25'h0, u_tab[i][6:0]} : 32'h0);
            clear_flags();
        end
        $display("unsigned to float test done");
    endtask

    task automatic t_guard();
        gp = 1'b1;
        n0 = wr_cnt;
        run_op(8'h7D, 3'h1, 2'h0, 32'hFF7F_FFFF, 32'hFFFF_FFFE, 7'h00);
        check({31'h0, got_en}, 32'h0);
        check(got_flags, 32'h0);
        run_op(8'h7E, 3'h4, 2'h0, 32'hFF7F_FFFF, 32'h0, 7'h00);
        check(wr_cnt, n0);
        run_op(8'h7D, 3'h1, 2'h0, 32'hFF7F_FFFF, 32'h1, 7'h00);
        check(got_flags, 32'h10);
        gp = 1'b0;
        run_op(8'h7F, 3'h4, 2'h0, 32'h3, 32'h0, 7'h00);
        check({31'h0, got_en}, 32'h1);
        @(negedge core_clk);
        check(wr_cnt, n0 + 32'h2);
        check({25'h0, last_dest}, 32'h03);
        clear_flags();
        $display("guard test done");
    endtask

    task automatic t_slots();
        for (int k = 0; k < 8; k++) begin
            run_op(8'h7D, k[2:0], 2'h0, 32'h4040_0000, 32'h0, 7'h00);
            check({31'h0, got_en}, {31'h0, k == 1 || k == 4});
            check({31'h0, got_ill}, {31'h0, k != 1 && k != 4});
        end
        run_op(8'h7C, 3'h1, 2'h0, 32'h4040_0000, 32'h0, 7'h00);
        check({30'h0, got_en, got_ill}, 32'h0);
        $display("slot test done");
    endtask

    task automatic t_sticky();
        @(negedge core_clk);
        ext = 7'h41;
        @(negedge core_clk);
        ext = 7'h00;
        repeat (5) @(negedge core_clk);
        check({25'h0, sw_flags}, 32'h41);
        {swr, swd, ext} = {1'b1, 7'h10, 7'h04};
        @(negedge core_clk);
        {swr, swd, ext} = {1'b0, 7'h00, 7'h00};
        check({25'h0, sw_flags}, 32'h14);
        clear_flags();
        run_op(8'h7D, 3'h1, 2'h0, 32'h4024_7AE1, 32'h0, 7'h08);
        check(got_flags, 32'h0A);
        clear_flags();
        $display("sticky flag test done");
    endtask

    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        check({24'h0, wr_en, sw_flags}, 32'h0);
        t_f2u();
        t_u2f();
        t_guard();
        t_slots();
        t_sticky();
        test_done();
    end

    initial begin
        #100000;
        error_cnt++;
        $display("watchdog expired");
        test_done();
    end
endmodule
`default_nettype wire
